// [hw/seq_pkg.sv]
// constants for the converter result sequencer
package seq_pkg;
	localparam int         INSTR_DEPTH   = 64;
	localparam int         IPTR_W        = 6;
	localparam logic [7:0] INSTR_RESET   = 8'h00;
	localparam int         BIT_CONT      = 7;
	localparam int         BIT_DIFF      = 6;
	localparam int         BIT_SECOND    = 5;
	localparam int         BIT_FIRST     = 4;
	localparam logic [15:0] PTR_STEP_ONE = 16'h0002;
	localparam logic [15:0] PTR_STEP_TWO = 16'h0004;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam logic [5:0]  IPTR_RESET   = 6'h00;
	localparam logic [5:0]  IPTR_ONE     = 6'h01;
endpackage

// [hw/adc_result_dma_sequencer.sv]
// result sequencer: instruction store, converter buffers, memory writer
`timescale 1ns/1ps

// ----------------------------------------
// Overview of operation
// ----------------------------------------
module adc_result_dma_sequencer (
	input  wire logic        SYS_CLK,        // system clock, 10 MHz
	input  wire logic        RESET,          // synchronous, active high
	input  wire logic [5:0]  IPTR_WDATA,     // instruction pointer write value
	input  wire logic        IPTR_WR,        // instruction pointer write strobe
	output logic      [5:0]  IPTR_VALUE,     // instruction pointer readback
	input  wire logic [7:0]  IDATA_WDATA,    // instruction data write value
	input  wire logic        IDATA_WR,       // instruction data write strobe
	input  wire logic        IDATA_RD,       // instruction data read strobe
	output logic      [7:0]  IDATA_RDATA,    // byte at instruction pointer
	input  wire logic        ENABLE_WR,      // enable bit write strobe
	input  wire logic        ENABLE_WDATA,   // enable value written
	output logic             ENABLE_STATUS,  // operation in progress
	input  wire logic        MODE_SELECT,    // 0 once per pass, 1 per-instruction repeat
	input  wire logic [5:0]  BOUNDARY,       // first instruction address
	input  wire logic [15:0] START_ADDR,     // start address pair
	input  wire logic [15:0] REPEAT_LIMIT,   // repeat limit pair
	output logic      [15:0] REPEAT_COUNT,   // repeat counter pair
	output logic      [15:0] WRITE_PTR,      // memory write pointer pair
	output logic      [5:0]  CURRENT_INSTR,  // current instruction address
	input  wire logic        FIRST_DONE,     // first converter result ready pulse
	input  wire logic [15:0] FIRST_RESULT,   // first converter result
	input  wire logic        SECOND_DONE,    // second converter result ready pulse
	input  wire logic [15:0] SECOND_RESULT,  // second converter result
	input  wire logic        OFFCHIP_SEL,    // target memory is off-chip
	input  wire logic        CORE_ONCHIP,    // core uses on-chip memory this cycle
	input  wire logic        HALT,           // off-chip halt bit
	input  wire logic        CORE_XREQ,      // core off-chip access request
	output logic             CORE_XACK,      // core off-chip access completion
	output logic             CORE_XPASS,     // core access reaches external memory
	output logic             MEM_WR,         // memory write strobe, 16 bits
	output logic      [15:0] MEM_ADDR,       // memory byte address
	output logic      [15:0] MEM_WDATA,      // memory write word
	output logic             MEM_OFFCHIP,    // write goes off-chip
	output logic             OFFCHIP_BUSY,   // sequencer accessing off-chip memory
	input  wire logic        FLAG_CLR,       // clear all sticky flags
	output logic             DONE_FLAG,      // operations complete, sticky
	output logic             EOO_FLAG,       // end instruction reached, sticky
	output logic             WARN_FIRST,     // first path warning
	output logic             WARN_SECOND,    // second path warning
	output logic             ERR_FIRST,      // first path error
	output logic             ERR_SECOND      // second path error
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_WAIT  = 4'b0010,
		S_WR1   = 4'b0100,
		S_WR2   = 4'b1000
	} state_type;

	state_type   state;
	logic [7:0]  store [seq_pkg::INSTR_DEPTH];
	logic [7:0]  instr;
	logic [15:0] first_reg;
	logic [15:0] second_reg;
	logic        first_full;
	logic        second_full;
	logic        first_pend;
	logic        second_pend;
	logic        want_first;
	logic        want_second;
	logic        is_end;
	logic        two_words;
	logic        ready;
	logic        slot_ok;
	logic        take;
	logic        start;
	logic        last_write;
	logic        stop;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign instr       = store[CURRENT_INSTR];
	assign is_end      = instr[6:4] == 3'b000;
	assign want_first  = instr[seq_pkg::BIT_FIRST] | instr[seq_pkg::BIT_DIFF];
	assign want_second = instr[seq_pkg::BIT_SECOND];
	assign two_words   = want_first & want_second;
	assign ready       = (!want_first || first_full) && (!want_second || second_full);
	// on-chip slots only when core is off the memory; off-chip only with halt clear
	assign slot_ok     = OFFCHIP_SEL ? !HALT : !CORE_ONCHIP;
	// a stop in a write slot wins: the word is neither written nor counted
	assign stop        = ENABLE_WR && !ENABLE_WDATA;
	assign take        = (state == S_WR1 || state == S_WR2) && slot_ok && !stop;
	assign last_write  = take && (state == S_WR2 || !two_words);
	assign start       = ENABLE_WR && ENABLE_WDATA && !ENABLE_STATUS;

	// ----------------------------------------
	// instruction store access
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (IDATA_WR)
			store[IPTR_VALUE] <= IDATA_WDATA;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			IPTR_VALUE <= seq_pkg::IPTR_RESET;
		else if (IPTR_WR)
			IPTR_VALUE <= IPTR_WDATA;
		else if (IDATA_WR || IDATA_RD)
			IPTR_VALUE <= IPTR_VALUE + seq_pkg::IPTR_ONE;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			IDATA_RDATA <= seq_pkg::INSTR_RESET;
		else
			IDATA_RDATA <= store[IPTR_VALUE];
	end

	// ----------------------------------------
	// converter double buffers
	// ----------------------------------------
	// results are only accepted, never requested: converters run on their own
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			first_full <= 1'b0;
			first_pend <= 1'b0;
			first_reg  <= seq_pkg::WORD_RESET;
		end else begin
			if (last_write && want_first) begin
				first_full <= first_pend;
				first_pend <= 1'b0;
				// a waiting word sits in the converter register until now
				if (first_pend)
					first_reg <= FIRST_RESULT;
			end
			if (FIRST_DONE && ENABLE_STATUS) begin
				if (!first_full || (last_write && want_first && !first_pend)) begin
					first_full <= 1'b1;
					first_reg  <= FIRST_RESULT;
				end else
					first_pend <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			second_full <= 1'b0;
			second_pend <= 1'b0;
			second_reg  <= seq_pkg::WORD_RESET;
		end else begin
			if (last_write && want_second) begin
				second_full <= second_pend;
				second_pend <= 1'b0;
				if (second_pend)
					second_reg <= SECOND_RESULT;
			end
			if (SECOND_DONE && ENABLE_STATUS) begin
				if (!second_full || (last_write && want_second && !second_pend)) begin
					second_full <= 1'b1;
					second_reg  <= SECOND_RESULT;
				end else
					second_pend <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// sticky flags: a set beats a clear
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			WARN_FIRST  <= 1'b0;
			WARN_SECOND <= 1'b0;
			ERR_FIRST   <= 1'b0;
			ERR_SECOND  <= 1'b0;
		end else begin
			WARN_FIRST  <= (FIRST_DONE && ENABLE_STATUS && first_full) | (WARN_FIRST & !FLAG_CLR);
			WARN_SECOND <= (SECOND_DONE && ENABLE_STATUS && second_full) | (WARN_SECOND & !FLAG_CLR);
			ERR_FIRST   <= (FIRST_DONE && ENABLE_STATUS && first_pend) | (ERR_FIRST & !FLAG_CLR);
			ERR_SECOND  <= (SECOND_DONE && ENABLE_STATUS && second_pend) | (ERR_SECOND & !FLAG_CLR);
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state         <= S_IDLE;
			ENABLE_STATUS <= 1'b0;
			CURRENT_INSTR <= seq_pkg::IPTR_RESET;
			REPEAT_COUNT  <= seq_pkg::COUNT_ZERO;
			WRITE_PTR     <= seq_pkg::WORD_RESET;
			DONE_FLAG     <= 1'b0;
			EOO_FLAG      <= 1'b0;
		end else begin
			if (FLAG_CLR) begin
				DONE_FLAG <= 1'b0;
				EOO_FLAG  <= 1'b0;
			end
			if (ENABLE_WR && !ENABLE_WDATA) begin
				state         <= S_IDLE;
				ENABLE_STATUS <= 1'b0;
			end else if (start) begin
				state         <= S_WAIT;
				ENABLE_STATUS <= 1'b1;
				CURRENT_INSTR <= BOUNDARY;
				WRITE_PTR     <= START_ADDR;
				REPEAT_COUNT  <= REPEAT_LIMIT;
			end else begin
				unique case (state)
					S_IDLE: ;
					S_WAIT: begin
						if (is_end) begin
							EOO_FLAG      <= 1'b1;
							CURRENT_INSTR <= BOUNDARY;
							if (!instr[seq_pkg::BIT_CONT] &&
								(MODE_SELECT || REPEAT_COUNT <= 16'h0001)) begin
								state         <= S_IDLE;
								ENABLE_STATUS <= 1'b0;
								DONE_FLAG     <= 1'b1;
							end
							if (!instr[seq_pkg::BIT_CONT] && !MODE_SELECT)
								REPEAT_COUNT <= REPEAT_COUNT - 16'h0001;
						end else if (ready)
							state <= S_WR1;
					end
					S_WR1: begin
						if (take) begin
							WRITE_PTR <= WRITE_PTR + 16'h0002;
							if (two_words)
								state <= S_WR2;
						end
					end
					S_WR2: begin
						if (take)
							WRITE_PTR <= WRITE_PTR + 16'h0002;
					end
					default: state <= S_IDLE;
				endcase
				if (last_write) begin
					state <= S_WAIT;
					if (!MODE_SELECT)
						CURRENT_INSTR <= CURRENT_INSTR + seq_pkg::IPTR_ONE;
					else if (REPEAT_COUNT <= 16'h0001) begin
						REPEAT_COUNT  <= REPEAT_LIMIT;
						CURRENT_INSTR <= CURRENT_INSTR + seq_pkg::IPTR_ONE;
					end else
						REPEAT_COUNT <= REPEAT_COUNT - 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------
	// memory port and core arbitration
	// ----------------------------------------
	// combined codes without differential store second first; differential comes from first register, then second
	always_comb begin
		MEM_WDATA = first_reg;
		if (state == S_WR1 && want_second && !(instr[seq_pkg::BIT_DIFF] && two_words))
			MEM_WDATA = second_reg;
		if (state == S_WR2 && instr[seq_pkg::BIT_DIFF])
			MEM_WDATA = second_reg;
	end

	assign MEM_WR       = take;
	assign MEM_ADDR     = WRITE_PTR;
	assign MEM_OFFCHIP  = OFFCHIP_SEL;
	assign OFFCHIP_BUSY = take && OFFCHIP_SEL;
	assign CORE_XACK    = CORE_XREQ;
	assign CORE_XPASS   = CORE_XREQ && HALT;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_core_blocked: assert property (@(posedge SYS_CLK) disable iff (RESET)
		CORE_XREQ && !HALT |-> CORE_XACK && !CORE_XPASS) else $error("core reached memory");
	a_onchip_yield: assert property (@(posedge SYS_CLK) disable iff (RESET)
		MEM_WR && !MEM_OFFCHIP |-> !CORE_ONCHIP) else $error("write during core use");
	a_halt_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
		MEM_WR && MEM_OFFCHIP |-> !HALT) else $error("off-chip write while halted");
	a_ptr_step: assert property (@(posedge SYS_CLK) disable iff (RESET)
		MEM_WR && !start |=> WRITE_PTR == $past(WRITE_PTR) + 16'h0002) else $error("bad step");
	a_iptr_inc: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(IDATA_WR || IDATA_RD) && !IPTR_WR |=> IPTR_VALUE == $past(IPTR_VALUE) + 6'h01)
		else $error("pointer not advanced");
	a_start_load: assert property (@(posedge SYS_CLK) disable iff (RESET)
		start |=> ENABLE_STATUS && WRITE_PTR == $past(START_ADDR)
		&& CURRENT_INSTR == $past(BOUNDARY)) else $error("start load wrong");
	a_count_load: assert property (@(posedge SYS_CLK) disable iff (RESET)
		start |=> REPEAT_COUNT == $past(REPEAT_LIMIT)) else $error("count not loaded");
	a_stop_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
		ENABLE_WR && !ENABLE_WDATA |=> !ENABLE_STATUS) else $error("stop ignored");
	a_end_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
		state == S_WAIT && is_end && !ENABLE_WR |=> EOO_FLAG && CURRENT_INSTR == $past(BOUNDARY))
		else $error("end not handled");
endmodule

// [test/conv_pair_model.sv]
// model of the two converters that feed the sequencer
`timescale 1ns/1ps
module conv_pair_model (
	input  wire logic        clk,      // system clock
	input  wire logic        go,       // request one result set
	input  wire logic [1:0]  sel,      // bit 0 first, bit 1 second
	input  wire logic [3:0]  delay,    // cycles to result, 1 or more
	input  wire logic [15:0] value_a,  // first value
	input  wire logic [15:0] value_b,  // second value
	output logic             done_a,   // first ready pulse
	output logic      [15:0] result_a, // first result register
	output logic             done_b,   // second ready pulse
	output logic      [15:0] result_b  // second result register
);
	logic [3:0] cnt = 4'h0;
	logic [1:0] pend = 2'h0;
	initial begin
		done_a = 1'h0;
		done_b = 1'h0;
		result_a = 16'h0000;
		result_b = 16'h0000;
	end
	// conversions start here only, never from the sequencer
	always @(posedge clk) begin
		done_a <= 1'h0;
		done_b <= 1'h0;
		if (go) begin
			cnt <= delay;
			pend <= sel;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) begin
				done_a <= pend[0];
				done_b <= pend[1];
				if (pend[0]) result_a <= value_a;
				if (pend[1]) result_b <= value_b;
			end
		end
	end
endmodule

// [test/adc_result_dma_sequencer_tb_top.sv]
// self-checking bench for the converter result sequencer
`timescale 1ns/1ps
module adc_result_dma_sequencer_tb_top;
	logic        SYS_CLK = 1'h0, RESET = 1'h1, IPTR_WR = 1'h0, IDATA_WR = 1'h0, IDATA_RD = 1'h0;
	logic        ENABLE_WR = 1'h0, ENABLE_WDATA = 1'h0, MODE_SELECT = 1'h0, OFFCHIP_SEL = 1'h0;
	logic        CORE_ONCHIP = 1'h0, HALT = 1'h0, CORE_XREQ = 1'h0, FLAG_CLR = 1'h0, c_go = 1'h0;
	logic [5:0]  IPTR_WDATA = 6'h00, BOUNDARY = 6'h00, IPTR_VALUE, CURRENT_INSTR;
	logic [7:0]  IDATA_WDATA = 8'h00, IDATA_RDATA;
	logic [15:0] START_ADDR = 16'h0000, REPEAT_LIMIT = 16'h0000, c_va = 16'h0000, c_vb = 16'h0000;
	logic [15:0] REPEAT_COUNT, WRITE_PTR, FIRST_RESULT, SECOND_RESULT, MEM_ADDR, MEM_WDATA, ptr;
	logic [1:0]  c_sel = 2'h0;
	logic [3:0]  c_delay = 4'h4;
	logic        ENABLE_STATUS, FIRST_DONE, SECOND_DONE, CORE_XACK, CORE_XPASS, MEM_WR;
	logic        MEM_OFFCHIP, OFFCHIP_BUSY, DONE_FLAG, EOO_FLAG, WARN_FIRST, WARN_SECOND;
	logic        ERR_FIRST, ERR_SECOND;
	int          bad_count = 0, checks_done = 0, i, r;

	adc_result_dma_sequencer DUT (
		.SYS_CLK(SYS_CLK), .RESET(RESET), .IPTR_WDATA(IPTR_WDATA), .IPTR_WR(IPTR_WR),
		.IPTR_VALUE(IPTR_VALUE), .IDATA_WDATA(IDATA_WDATA), .IDATA_WR(IDATA_WR),
		.IDATA_RD(IDATA_RD), .IDATA_RDATA(IDATA_RDATA), .ENABLE_WR(ENABLE_WR),
		.ENABLE_WDATA(ENABLE_WDATA), .ENABLE_STATUS(ENABLE_STATUS), .MODE_SELECT(MODE_SELECT),
		.BOUNDARY(BOUNDARY), .START_ADDR(START_ADDR), .REPEAT_LIMIT(REPEAT_LIMIT),
		.REPEAT_COUNT(REPEAT_COUNT), .WRITE_PTR(WRITE_PTR), .CURRENT_INSTR(CURRENT_INSTR),
		.FIRST_DONE(FIRST_DONE), .FIRST_RESULT(FIRST_RESULT), .SECOND_DONE(SECOND_DONE),
		.SECOND_RESULT(SECOND_RESULT), .OFFCHIP_SEL(OFFCHIP_SEL), .CORE_ONCHIP(CORE_ONCHIP),
		.HALT(HALT), .CORE_XREQ(CORE_XREQ), .CORE_XACK(CORE_XACK), .CORE_XPASS(CORE_XPASS),
		.MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_OFFCHIP(MEM_OFFCHIP),
		.OFFCHIP_BUSY(OFFCHIP_BUSY), .FLAG_CLR(FLAG_CLR), .DONE_FLAG(DONE_FLAG),
		.EOO_FLAG(EOO_FLAG), .WARN_FIRST(WARN_FIRST), .WARN_SECOND(WARN_SECOND),
		.ERR_FIRST(ERR_FIRST), .ERR_SECOND(ERR_SECOND));
	conv_pair_model conv (.clk(SYS_CLK), .go(c_go), .sel(c_sel), .delay(c_delay),
		.value_a(c_va), .value_b(c_vb), .done_a(FIRST_DONE), .result_a(FIRST_RESULT),
		.done_b(SECOND_DONE), .result_b(SECOND_RESULT));

	// ----
	// tasks
	// ----
	task automatic tick(input int n = 1);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic set_ptr(input logic [5:0] a);
		IPTR_WDATA = a;
		IPTR_WR = 1'h1;
		tick();
		IPTR_WR = 1'h0;
	endtask
	task automatic load(input logic [5:0] a, input logic [31:0] w, input int n);
		set_ptr(a);
		IDATA_WR = 1'h1;
		for (int k = 0; k < n; k++) begin
			IDATA_WDATA = w[31-8*k -: 8];
			tick();
		end
		IDATA_WR = 1'h0;
	endtask
	task automatic start(input logic m, input logic [5:0] b, input logic [15:0] a,
		input logic [15:0] lim);
		MODE_SELECT = m;
		BOUNDARY = b;
		START_ADDR = a;
		REPEAT_LIMIT = lim;
		ptr = a;
		ENABLE_WDATA = 1'h1;
		ENABLE_WR = 1'h1;
		tick();
		ENABLE_WR = 1'h0;
		check(ENABLE_STATUS, 1'h1);
		check(WRITE_PTR, a);
		check(CURRENT_INSTR, b);
		check(REPEAT_COUNT, lim);
	endtask
	task automatic conv_req(input logic [1:0] s, input logic [15:0] a, input logic [15:0] b);
		c_sel = s;
		c_va = a;
		c_vb = b;
		c_go = 1'h1;
		tick();
		c_go = 1'h0;
	endtask
	task automatic hold_off(input int n);
		repeat (n) begin
			tick();
			check(MEM_WR, 1'h0);
		end
	endtask
	task automatic exp_wr(input logic [15:0] d);
		int n;
		// write strobe is combinational: look at it mid-cycle, once settled
		@(negedge SYS_CLK);
		for (n = 0; n < 300 && MEM_WR !== 1'h1; n++) @(negedge SYS_CLK);
		if (n == 300) begin
			bad_count++;
			summarize();
		end
		check(MEM_ADDR, ptr);
		check(MEM_WDATA, d);
		check(OFFCHIP_BUSY, OFFCHIP_SEL);
		check(MEM_OFFCHIP, OFFCHIP_SEL);
		ptr = ptr + 16'h0002;
		tick();
		check(WRITE_PTR, ptr);
	endtask
	task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b,
		input logic stall);
		conv_req({c[5], c[4] | c[6]}, a, b);
		if (stall) hold_off(10);
		CORE_ONCHIP = 1'h0;
		if (c[6]) begin
			exp_wr(a);
			if (c[5]) exp_wr(b);
		end else if (c[5] && c[4]) begin
			exp_wr(b);
			exp_wr(a);
		end else exp_wr(c[5] ? b : a);
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 60 && ENABLE_STATUS !== 1'h0; n++) tick();
		if (n == 60) begin
			bad_count++;
			summarize();
		end
	endtask

	// ----
	// sequence
	// ----
	initial begin
		forever #50 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		tick(8);
		RESET = 1'h0;
		check(IPTR_VALUE, seq_pkg::IPTR_RESET);
		check(ENABLE_STATUS, 1'h0);
		load(6'h3e, 32'ha55a0000, 2);
		check(IPTR_VALUE, 6'h00);
		set_ptr(6'h3e);
		tick();
		check(IDATA_RDATA, 8'ha5);
		IDATA_RD = 1'h1;
		tick();
		IDATA_RD = 1'h0;
		check(IPTR_VALUE, 6'h3f);
		tick();
		check(IDATA_RDATA, 8'h5a);
		// two passes of once-per-pass mode, first write stalled by the core
		load(6'h04, 32'h10604000, 4);
		start(1'h0, 6'h04, 16'h4000, 16'h0002);
		for (r = 0; r < 2; r++) begin
			CORE_ONCHIP = (r == 0);
			run(8'h10, 16'h1a00 + 16'(r), 16'h2a00, r == 0);
			run(8'h60, 16'h1b00 + 16'(r), 16'h2b00 + 16'(r), 1'h0);
			run(8'h40, 16'h1c00 + 16'(r), 16'h2c00, 1'h0);
			if (r == 0) begin
				tick(2);
				check(CURRENT_INSTR, 6'h04);
				check(EOO_FLAG, 1'h1);
				check(REPEAT_COUNT, 16'h0001);
			end
		end
		wait_idle();
		check(DONE_FLAG, 1'h1);
		check(REPEAT_COUNT, seq_pkg::COUNT_ZERO);
		FLAG_CLR = 1'h1;
		tick();
		FLAG_CLR = 1'h0;
		check(DONE_FLAG, 1'h0);
		check(EOO_FLAG, 1'h0);
		// per-instruction repeat mode, results arrive promptly
		c_delay = 4'h1;
		load(6'h0a, 32'h20700000, 3);
		start(1'h1, 6'h0a, 16'h5000, 16'h0002);
		for (i = 0; i < 2; i++) begin
			for (r = 0; r < 2; r++) begin
				run(i ? 8'h70 : 8'h20, 16'h3000 + 16'(2*i+r), 16'h4000 + 16'(2*i+r), 1'h0);
				tick();
				check(REPEAT_COUNT, r ? 16'h0002 : 16'h0001);
				if (i + r < 2) check(CURRENT_INSTR, 6'h0a + 6'(i + r));
			end
		end
		wait_idle();
		check(DONE_FLAG, 1'h1);
		// off-chip target held by the core: pending word, warning, error
		load(6'h14, 32'h10800000, 2);
		OFFCHIP_SEL = 1'h1;
		HALT = 1'h1;
		CORE_XREQ = 1'h1;
		start(1'h0, 6'h14, 16'h6000, 16'h0001);
		check(CORE_XPASS, 1'h1);
		// second converter runs too but is never selected: its words stay put
		conv_req(2'h3, 16'h7001, 16'h8001);
		hold_off(6);
		conv_req(2'h3, 16'h7002, 16'h8002);
		hold_off(4);
		check(WARN_FIRST, 1'h1);
		check(WARN_SECOND, 1'h1);
		check(ERR_FIRST, 1'h0);
		conv_req(2'h3, 16'h7003, 16'h8003);
		hold_off(4);
		check(ERR_FIRST, 1'h1);
		check(ERR_SECOND, 1'h1);
		HALT = 1'h0;
		#1;
		check(CORE_XACK, 1'h1);
		check(CORE_XPASS, 1'h0);
		exp_wr(16'h7001);
		exp_wr(16'h7003);
		tick(2);
		check(ENABLE_STATUS, 1'h1);
		check(CURRENT_INSTR, 6'h14);
		ENABLE_WDATA = 1'h0;
		ENABLE_WR = 1'h1;
		tick();
		ENABLE_WR = 1'h0;
		check(ENABLE_STATUS, 1'h0);
		FLAG_CLR = 1'h1;
		tick();
		FLAG_CLR = 1'h0;
		check(WARN_FIRST, 1'h0);
		check(ERR_SECOND, 1'h0);
		summarize();
	end
endmodule
